/* File: src/tsp_timer.v */
// Single-pulse and capture timer core with APB register access
// What this block does
// - Mode 10 with pin field 11 selects pulse
// - Software run rise starts the pulse
// - Trigger pin edge sets run bit automatically
// - Run rise starts counter, output goes active
// - Pulse ends on run clear or A match
// - A match clears run bit in pulse mode
// - A match raises interrupt in pulse mode
// - Counter zeroed only on run rise in pulse mode
// - Compare P, clear select, swap ignored here
// - Mode 01 selects capture input
// - Capture counter starts on run rise
// - Capture edge copies counter into compare A
// - Pin field picks rising, falling or both
// - Pin field 11 disables capture, counting continues
// - Capture counter free-runs until run falls
// - P match zeroes counter in capture mode
// - P match raises interrupt in capture mode
// - Compare P zero gives full count
// - Output controls unused in capture mode
// - Compare P against counter bits 15..8
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`include "tsp_defs.vh"

module tsp_timer #(
    parameter CNT_W = 16,
    parameter CMPP_W = 8
)
(
    input wire clock,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire timer_tick,
    input wire ext_clock_trigger_pin,
    input wire capture_input_pin,
    output reg timer_out,
    output wire timer_irq
);

    // Registers
    reg [7:0] ctrl0_q;
    reg [7:0] ctrl1_q;
    reg [CNT_W-1:0] count_q;
    reg [CNT_W-1:0] compare_a_value_q;
    reg [CMPP_W-1:0] compare_p_value_q;
    reg run_q;
    reg run_prev_q;
    reg trig_prev_q;
    reg capt_prev_q;
    wire flag_a_q;
    wire flag_p_q;
    wire flag_c_q;

    wire wr_en;
    wire rd_en;
    wire mode_sel_hi;
    wire mode_sel_lo;
    wire pin_func_hi;
    wire pin_func_lo;
    wire [1:0] mode;
    wire [1:0] pin_func;
    wire pulse_mode;
    wire capt_mode;
    wire run_rise;
    wire trig_edge;
    wire capt_rise;
    wire capt_fall;
    wire capt_hit;
    wire match_a;
    wire match_p;
    wire sw_run_wr;
    wire sw_run_val;
    wire [CNT_W-1:0] count_inc;

    // Decoded strobes and event terms
    wire wr_ctrl0;
    wire wr_ctrl1;
    wire wr_cmpa;
    wire wr_cmpp;
    wire wr_stat;
    wire [CMPP_W-1:0] cmpp_last;
    wire pulse_stop;
    wire set_a;
    wire set_p;
    wire set_c;
    wire clr_a;
    wire clr_p;
    wire clr_c;

    // Access strobes; the slave never stalls
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Field decode
    assign mode_sel_hi = ctrl1_q[`TSP_C1_MODE_HI];
    assign mode_sel_lo = ctrl1_q[`TSP_C1_MODE_LO];
    assign pin_func_hi = ctrl1_q[`TSP_C1_PIN_HI];
    assign pin_func_lo = ctrl1_q[`TSP_C1_PIN_LO];
    assign mode = {mode_sel_hi, mode_sel_lo};
    assign pin_func = {pin_func_hi, pin_func_lo};
    assign pulse_mode = (mode == `TSP_MODE_PULSE) && (pin_func == `TSP_PIN_PULSE);
    assign capt_mode = (mode == `TSP_MODE_CAPT);

    // Edges seen against last cycle's sampled run and pin levels
    // Pins are taken as synchronous; a raw async source needs a synchroniser
    assign run_rise = run_q & ~run_prev_q;
    assign trig_edge = ctrl0_q[`TSP_C0_TRIG_EDGE] ? (trig_prev_q & ~ext_clock_trigger_pin)
                                                  : (~trig_prev_q & ext_clock_trigger_pin);
    assign capt_rise = capture_input_pin & ~capt_prev_q;
    assign capt_fall = ~capture_input_pin & capt_prev_q;

    // Edge select for capture; code 11 blocks it
    // Capture only while running; an idle counter has nothing to store
    assign capt_hit = capt_mode && run_q && (
        (pin_func == `TSP_PIN_RISE && capt_rise) ||
        (pin_func == `TSP_PIN_FALL && capt_fall) ||
        (pin_func == `TSP_PIN_BOTH && (capt_rise | capt_fall)));

    // Comparators only act on a tick of a running counter; the run-rise
    // cycle is skipped because the counter still holds its stale value then
    assign match_a = run_q && timer_tick && !run_rise && (count_q == compare_a_value_q);
    // P period is value*256 ticks, so the match sits on the last count of
    // that span; zero wraps to all ones and gives the full counter range
    assign cmpp_last = compare_p_value_q - {{(CMPP_W-1){1'b0}}, 1'b1};
    assign match_p = run_q && timer_tick && !run_rise &&
                     (count_q[CNT_W-1:CNT_W-CMPP_W] == cmpp_last) &&
                     (count_q[CNT_W-CMPP_W-1:0] == {(CNT_W-CMPP_W){1'b1}});

    // Per-register write strobes; unmapped offsets are dropped
    assign wr_ctrl0 = wr_en && (paddr == `TSP_OFF_CTRL0);
    assign wr_ctrl1 = wr_en && (paddr == `TSP_OFF_CTRL1);
    assign wr_cmpa = wr_en && (paddr == `TSP_OFF_CMPA);
    assign wr_cmpp = wr_en && (paddr == `TSP_OFF_CMPP);
    assign wr_stat = wr_en && (paddr == `TSP_OFF_STAT);

    // Event sources and write-one clears for the sticky flags
    assign pulse_stop = pulse_mode && match_a;
    assign set_a = pulse_stop;
    assign set_p = capt_mode && match_p;
    assign set_c = capt_hit;
    assign clr_a = wr_stat && pwdata[`TSP_ST_AF];
    assign clr_p = wr_stat && pwdata[`TSP_ST_PF];
    assign clr_c = wr_stat && pwdata[`TSP_ST_CF];

    assign sw_run_wr = wr_ctrl0;
    assign sw_run_val = pwdata[`TSP_C0_RUN];
    assign count_inc = count_q + `TSP_ONE16;

    // Run bit: pin trigger sets, A match clears in pulse mode
    // The A match wins so a trigger cannot stretch a finished pulse
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            run_q <= 1'b0;
        end
        else if (pulse_mode && match_a)
        begin
            run_q <= 1'b0;
        end
        else if (pulse_mode && trig_edge && !run_q)
        begin
            run_q <= 1'b1;
        end
        else if (sw_run_wr)
        begin
            run_q <= sw_run_val;
        end
    end

    // Control and compare registers written by software
    // Bits that this block ignores are still stored; control 0 bits 2..0 read back as zero
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ctrl0_q <= `TSP_RST_BYTE;
            ctrl1_q <= `TSP_RST_BYTE;
            compare_p_value_q <= `TSP_ZERO8;
        end
        else
        begin
            if (wr_ctrl0)
            begin
                ctrl0_q <= pwdata[7:0];
            end
            if (wr_ctrl1)
            begin
                ctrl1_q <= pwdata[7:0];
            end
            if (wr_cmpp)
            begin
                compare_p_value_q <= pwdata[CMPP_W-1:0];
            end
        end
    end

    // Compare A: capture has priority over a software write
    // A capture and a write in one cycle keep the captured count
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            compare_a_value_q <= `TSP_RST_WORD;
        end
        else if (capt_hit)
        begin
            compare_a_value_q <= count_q;
        end
        else if (wr_cmpa)
        begin
            compare_a_value_q <= pwdata[CNT_W-1:0];
        end
    end

    // Counter; zeroed only on run rise, P wrap in capture
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            count_q <= `TSP_RST_WORD;
        end
        else if (run_rise)
        begin
            count_q <= `TSP_RST_WORD;
        end
        else if (capt_mode && match_p)
        begin
            count_q <= `TSP_RST_WORD;
        end
        else if (pulse_stop)
        begin
            // Counter stops on the A value that ended the pulse
            count_q <= count_q;
        end
        else if (run_q && timer_tick)
        begin
            count_q <= count_inc;
        end
    end

    // Sampled history for edge detection
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            run_prev_q <= 1'b0;
            trig_prev_q <= 1'b0;
            capt_prev_q <= 1'b0;
        end
        else
        begin
            run_prev_q <= run_q;
            trig_prev_q <= ext_clock_trigger_pin;
            capt_prev_q <= capture_input_pin;
        end
    end

    // Pulse output: active while running in pulse mode
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            timer_out <= 1'b0;
        end
        else if (pulse_mode)
        begin
            // Active level from initial-level bit, then polarity flip
            timer_out <= (run_q ~^ ctrl1_q[`TSP_C1_INIT]) ^ ~ctrl1_q[`TSP_C1_POL] ^ 1'b1;
        end
        else
        begin
            timer_out <= 1'b0;
        end
    end

    // Sticky event flags; a new event wins over a clear
    // A match in pulse mode
    tsp_sticky_flag u_flag_a (
        .clock(clock),
        .reset(reset),
        .set_evt(set_a),
        .clr_req(clr_a),
        .flag_q(flag_a_q)
    );

    // P match in capture mode
    tsp_sticky_flag u_flag_p (
        .clock(clock),
        .reset(reset),
        .set_evt(set_p),
        .clr_req(clr_p),
        .flag_q(flag_p_q)
    );

    // Capture edge seen
    tsp_sticky_flag u_flag_c (
        .clock(clock),
        .reset(reset),
        .set_evt(set_c),
        .clr_req(clr_c),
        .flag_q(flag_c_q)
    );

    // Timer request is the plain OR of pending events
    // Level request, stays up until every pending flag is cleared
    assign timer_irq = flag_a_q | flag_p_q | flag_c_q;

    // Read data registered for the access phase
    // Loaded at setup so reads never need a wait state
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            prdata <= 32'h00000000;
        end
        else if (rd_en && !penable)
        begin
            case (paddr)
                `TSP_OFF_CTRL0: prdata <= {24'h000000, ctrl0_q[7:4], run_q, 3'h0};
                `TSP_OFF_CTRL1: prdata <= {24'h000000, ctrl1_q};
                `TSP_OFF_CNT: prdata <= {{(32-CNT_W){1'b0}}, count_q};
                `TSP_OFF_CMPA: prdata <= {{(32-CNT_W){1'b0}}, compare_a_value_q};
                `TSP_OFF_CMPP: prdata <= {{(32-CMPP_W){1'b0}}, compare_p_value_q};
                `TSP_OFF_STAT: prdata <= {29'h00000000, flag_c_q, flag_p_q, flag_a_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// Sticky flag: an event sets it, a write-one clear drops it. Set is
// checked first so an event landing in the clear cycle is never lost.
module tsp_sticky_flag (
    input wire clock,
    input wire reset,
    input wire set_evt,
    input wire clr_req,
    output reg flag_q
);

    // Set priority over clear
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            flag_q <= 1'b0;
        end
        else if (set_evt)
        begin
            flag_q <= 1'b1;
        end
        else if (clr_req)
        begin
            flag_q <= 1'b0;
        end
    end

endmodule

/* File: src/tsp_defs.vh */
// Constants for the single-pulse and capture timer block
`ifndef TSP_DEFS_VH
`define TSP_DEFS_VH

// Register byte offsets on APB
`define TSP_OFF_CTRL0 12'h000
`define TSP_OFF_CTRL1 12'h004
`define TSP_OFF_CNT 12'h008
`define TSP_OFF_CMPA 12'h00c
`define TSP_OFF_CMPP 12'h010
`define TSP_OFF_STAT 12'h014

// Control 0 fields
`define TSP_C0_RUN 3
`define TSP_C0_TRIG_EDGE 4

// Control 1 fields
`define TSP_C1_MODE_HI 7
`define TSP_C1_MODE_LO 6
`define TSP_C1_PIN_HI 5
`define TSP_C1_PIN_LO 4
`define TSP_C1_INIT 3
`define TSP_C1_POL 2
`define TSP_C1_CCLR 0
`define TSP_C1_DPX 1

// Status fields, write one to clear
`define TSP_ST_AF 0
`define TSP_ST_PF 1
`define TSP_ST_CF 2

// Mode and pin-function codes
`define TSP_MODE_CAPT 2'h1
`define TSP_MODE_PULSE 2'h2
`define TSP_PIN_RISE 2'h0
`define TSP_PIN_FALL 2'h1
`define TSP_PIN_BOTH 2'h2
`define TSP_PIN_PULSE 2'h3

// Reset values
`define TSP_RST_BYTE 8'h00
`define TSP_RST_WORD 16'h0000
`define TSP_ONE16 16'h0001
`define TSP_ZERO8 8'h00

`endif

/* File: verification/tsp_pins_model.sv */
// Far-side pin sources: trigger and capture
`timescale 1ns/100ps
module tsp_pins_model (
    input wire clock,
    output reg trig_pin,
    output reg cap_pin
);
    initial
    begin
        trig_pin = 1'b0;
        cap_pin = 1'b0;
    end
    // Held four clocks so any input sync depth sees it
    task trig_pulse;
    begin
        @(posedge clock);
        trig_pin <= 1'b1;
        repeat (4) @(posedge clock);
        trig_pin <= 1'b0;
    end
    endtask
    // Capture pin level step
    task cap_set(input v);
    begin
        @(posedge clock);
        cap_pin <= v;
    end
    endtask
endmodule

/* File: verification/tsp_timer_monitor.sv */
// Port checker for the pulse and capture timer
`timescale 1ns/100ps
module tsp_timer_monitor (
    input wire clock,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire timer_tick,
    input wire ext_clock_trigger_pin,
    input wire capture_input_pin,
    input wire timer_out,
    input wire timer_irq
);
    reg [5:0] act_q;
    reg [1:0] pin_q;
    wire wr = psel & penable & pwrite;
    wire rds = psel & !penable & !pwrite;
    wire act_d = timer_tick | wr | (pin_q != {ext_clock_trigger_pin, capture_input_pin});
    // Six-deep cause window, since the pin sync depth is hidden
    always @(posedge clock or posedge reset)
        if (reset)
            {act_q, pin_q} <= 8'h00;
        else
            {act_q, pin_q} <= {act_q[4:0], act_d, ext_clock_trigger_pin, capture_input_pin};
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_rdy; pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready low");
    property p_err; !pslverr; endproperty
    a_err: assert property (p_err) else $error("slave error");
    property p_unmap; rds && paddr == 12'h018 |=> prdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_hold; !$past(rds) |-> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rst; $fell(reset) |-> !timer_out && !timer_irq; endproperty
    a_rst: assert property (p_rst) else $error("outputs after reset");
    property p_irqdn; $fell(timer_irq) |-> $past(wr && paddr == 12'h014); endproperty
    a_irqdn: assert property (p_irqdn) else $error("irq fell alone");
    property p_irqup;
        $rose(timer_irq) |-> $past(timer_tick) || ($past(capture_input_pin) != $past(capture_input_pin, 2));
    endproperty
    a_irqup: assert property (p_irqup) else $error("irq rose alone");
    property p_out; timer_out != $past(timer_out) |-> |act_q; endproperty
    a_out: assert property (p_out) else $error("out moved alone");
    c_pulse: cover property ($rose(timer_out));
    c_irq: cover property ($rose(timer_irq));
    c_clr: cover property ($fell(timer_irq));
endmodule
bind tsp_timer tsp_timer_monitor mon (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .ext_clock_trigger_pin(ext_clock_trigger_pin),
    .capture_input_pin(capture_input_pin), .timer_out(timer_out), .timer_irq(timer_irq));

/* File: verification/tsp_timer_tb.sv */
// Self-checking bench for the pulse and capture timer
`timescale 1ns/100ps
`include "tsp_defs.vh"
module tsp_timer_tb;
    reg clock = 1'b0;
    reg reset = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg timer_tick = 1'b0;
    reg [31:0] rd_v;
    reg [75:0] rows [0:3];
    wire [31:0] prdata;
    wire pready, pslverr, trig, cap, timer_out, timer_irq;
    integer n_fail = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer i;
    integer k;
    tsp_timer dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_tick(timer_tick), .ext_clock_trigger_pin(trig), .capture_input_pin(cap),
        .timer_out(timer_out), .timer_irq(timer_irq));
    tsp_pins_model pins (.clock(clock), .trig_pin(trig), .cap_pin(cap));
    always #2 clock = ~clock;
    task give_verdict;
    begin
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // Hang guard, well above the run length
    always @(posedge clock)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            n_fail = n_fail + 1;
            give_verdict;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // Request held until pready is seen high
    task apb(input [11:0] a, input w, input [31:0] d);
    begin
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd_v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task wait_out(input v);
    begin
        for (i = 0; i < 300 && timer_out !== v; i = i + 1)
            @(posedge clock);
        chk(timer_out, v);
    end
    endtask
    initial
    begin
        rows[0] = {`TSP_OFF_CMPA, 32'hffff_1234, 32'h0000_1234};
        rows[1] = {`TSP_OFF_CMPP, 32'h0000_01ab, 32'h0000_00ab};
        rows[2] = {`TSP_OFF_CNT, 32'h0000_0055, 32'h0};
        rows[3] = {12'h018, 32'hffff_ffff, 32'h0};
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        timer_tick <= 1'b1;
        chk({timer_out, timer_irq}, 0);
        // Counter row: stopped, so it must still read zero
        for (k = 0; k < 4; k = k + 1)
        begin
            apb(rows[k][75:64], 1'b1, rows[k][63:32]);
            apb(rows[k][75:64], 1'b0, 32'h0);
            chk(rd_v, rows[k][31:0]);
        end
        $display("register rows done");
        apb(`TSP_OFF_CTRL1, 1'b1, 32'h0000_00bb);
        apb(`TSP_OFF_CMPA, 1'b1, 32'h0000_0010);
        apb(`TSP_OFF_CTRL0, 1'b1, 32'h0000_0008);
        wait_out(1'b1);
        wait_out(1'b0);
        apb(`TSP_OFF_CTRL0, 1'b0, 32'h0);
        chk(rd_v[3], 0);
        apb(`TSP_OFF_CNT, 1'b0, 32'h0);
        chk(rd_v, 32'h0000_0010);
        apb(`TSP_OFF_STAT, 1'b0, 32'h0);
        chk(rd_v[0] & timer_irq, 1);
        apb(`TSP_OFF_STAT, 1'b1, 32'h7);
        @(posedge clock);
        chk(timer_irq, 0);
        apb(`TSP_OFF_CTRL0, 1'b1, 32'h8);
        repeat (3) @(posedge clock);
        chk(timer_out, 1);
        apb(`TSP_OFF_CTRL0, 1'b1, 32'h0);
        wait_out(1'b0);
        apb(`TSP_OFF_CNT, 1'b0, 32'h0);
        chk(rd_v < 32'h8, 1);
        pins.trig_pulse;
        wait_out(1'b1);
        wait_out(1'b0);
        $display("pulse tests done");
        apb(`TSP_OFF_CMPP, 1'b1, 32'h1);
        for (k = 0; k < 4; k = k + 1)
        begin
            apb(`TSP_OFF_CTRL1, 1'b1, 32'h4f | (k << 4));
            apb(`TSP_OFF_STAT, 1'b1, 32'h7);
            apb(`TSP_OFF_CTRL0, 1'b1, 32'h8);
            pins.cap_set(1'b1);
            repeat (6) @(posedge clock);
            apb(`TSP_OFF_STAT, 1'b0, 32'h0);
            chk({timer_out, rd_v[2]}, k == 0 || k == 2);
            apb(`TSP_OFF_STAT, 1'b1, 32'h4);
            pins.cap_set(1'b0);
            repeat (6) @(posedge clock);
            apb(`TSP_OFF_STAT, 1'b0, 32'h0);
            chk(rd_v[2], k == 1 || k == 2);
            apb(`TSP_OFF_CTRL0, 1'b1, 32'h0);
        end
        apb(`TSP_OFF_CTRL1, 1'b1, 32'h4f);
        apb(`TSP_OFF_CTRL0, 1'b1, 32'h8);
        repeat (10) @(posedge clock);
        pins.cap_set(1'b1);
        repeat (2) @(posedge clock);
        apb(`TSP_OFF_CMPA, 1'b0, 32'h0);
        chk(rd_v, 32'h0000_000a);
        timer_tick <= 1'b0;
        apb(`TSP_OFF_CNT, 1'b0, 32'h0);
        k = rd_v;
        apb(`TSP_OFF_CNT, 1'b0, 32'h0);
        chk(rd_v, k);
        timer_tick <= 1'b1;
        repeat (600) @(posedge clock);
        apb(`TSP_OFF_STAT, 1'b0, 32'h0);
        chk(rd_v[1], 1);
        apb(`TSP_OFF_CNT, 1'b0, 32'h0);
        chk(rd_v < 32'h100, 1);
        $display("capture tests done");
        give_verdict;
    end
endmodule
